// >>> lpsc_map.vh
// register map and constants for the low-power stop mode controller
`ifndef LPSC_MAP_VH
`define LPSC_MAP_VH

// register word addresses (one per register, consecutive)
`define LPSC_ADDR_SYS_OPT      4'h0
`define LPSC_ADDR_PWR_CTRL_ONE 4'h1
`define LPSC_ADDR_PWR_CTRL_TWO 4'h2
`define LPSC_ADDR_DBG_CTRL     4'h3
`define LPSC_ADDR_CLK_CTRL     4'h4
`define LPSC_ADDR_STATUS       4'h5

// field positions
`define LPSC_BIT_STOP_EN       0
`define LPSC_BIT_LVD_EN        0
`define LPSC_BIT_LVD_STOP_EN   1
`define LPSC_BIT_PPD_SEL       0
`define LPSC_BIT_PPD_FLAG      1
`define LPSC_BIT_PPD_ACK       2
`define LPSC_BIT_DBG_EN        0
`define LPSC_BIT_IRCLK_EN      0
`define LPSC_BIT_IREF_STEN     1
`define LPSC_BIT_ERCLK_EN      2
`define LPSC_BIT_EREF_STEN     3
`define LPSC_BIT_HF_RANGE      4
`define LPSC_BIT_ADC_ACLK      5

// reset values
`define LPSC_RST_SYS_OPT       8'h01
`define LPSC_RST_PWR_ONE       8'h00
`define LPSC_RST_PWR_TWO       8'h00
`define LPSC_RST_DBG           8'h00
`define LPSC_RST_CLK           8'h00
// deep wake leaves the detector enabled
`define LPSC_POR_PWR_ONE       8'h01

// state codes
`define LPSC_ST_RUN            2'h0
`define LPSC_ST_SHALLOW        2'h1
`define LPSC_ST_DEEP           2'h2
`define LPSC_ST_BKGD           2'h3

`endif

// >>> lpsc_stop_ctrl.v
// low-power stop mode controller with avalon-mm register slave
//
// Functional notes
// (RULE_01) stop with stop enable clear raises illegal-opcode reset, no stop.
// (RULE_02) debug enabled selects shallow stop with debug clocks kept alive.
// (RULE_03) both detector enables: shallow stop, regulator on, select ignored.
// (RULE_04) otherwise power-down select 0 gives shallow, 1 gives deep stop.
// (RULE_05) both stop states halt internal clocks; reference clocks optional. The code lets them run in shallow stop only.
// (RULE_06) shallow stop preserves registers, ram and pin levels.
// (RULE_07) shallow exit on reset pin, irq pin or port a/b/d/j pins.
// (RULE_08) shallow exit on lvd, lvw, adc, comparator, rtc, can, serial wakes.
// (RULE_09) reset-pin exit takes reset vector; interrupt exit its own vector.
// (RULE_10) both detector enables at stop keep regulator active throughout.
// (RULE_11) debug enabled at stop keeps debug clock and full regulation.
// (RULE_12) stopped: status memory commands refused with stop/wait error.
// (RULE_13) background command in stop with debug on wakes to background.
// (RULE_14) deep stop powers down all but ram and latches pin controls.
// (RULE_15) deep stop exits only on reset pin or enabled rtc wake.
// (RULE_16) deep wake acts as power-on reset with low lvd trip point.
// (RULE_17) deep wake sets recovery flag; flag and latches hold until ack.
// (RULE_18) software restores port values before ack, else pins reset.
// (RULE_19) after ack, unenabled peripheral pins follow port registers.
// (RULE_20) any stop state gates all peripheral clocks, even with debug.
// (RULE_21) shallow: adc needs async clock and lvd; comparator needs lvd.
// (RULE_22) shallow: oscillator needs clock and stop enables; hf also lvd.
// (RULE_23) writing ack 1 clears recovery flag and opens latches together.
`timescale 1ns/1ps
`default_nettype none
`include "lpsc_map.vh"

module lpsc_stop_ctrl
#(
    parameter WAKE_W = 32
)
(
    input  wire              clock,
    input  wire              rst_n,
    // avalon-mm slave
    input  wire [3:0]        avs_address,
    input  wire              avs_read,
    input  wire              avs_write,
    input  wire [31:0]       avs_writedata,
    output reg  [31:0]       avs_readdata,
    output wire              avs_waitrequest,
    // core
    input  wire              stop_exec,
    output reg               illegal_op_reset,
    output reg               reset_vector_fetch,
    output reg               irq_vector_fetch,
    output reg               por_like_reset,
    output reg               lvd_low_trip_sel,
    // wake sources (pins, asynchronous)
    input  wire              reset_pin_n,
    input  wire              irq_pin,
    input  wire [WAKE_W-1:0] port_pin_irq,
    // internal wake events (same clock)
    input  wire              lvd_reset_evt,
    input  wire              lvw_irq_evt,
    input  wire              adc_done_irq,
    input  wire              cmp_irq,
    input  wire              rtc_irq,
    input  wire              rtc_enabled,
    input  wire              can_wake_irq,
    input  wire              serial_rx_irq,
    // debug command path
    input  wire              dbg_bkgd_cmd,
    input  wire              dbg_mem_status_cmd,
    output reg               dbg_mem_refused,
    output reg               dbg_err_stopwait,
    output wire              dbg_accept_all,
    // power and clock controls
    output wire              core_clk_en,
    output wire              periph_clk_en,
    output wire              dbg_clk_en,
    output wire              regulator_active,
    output wire              power_down_n,
    output wire              pin_latch_hold,
    output wire              ram_retain,
    output wire              ref_irclk_run,
    output wire              ref_erclk_run,
    output wire              adc_run_in_stop,
    output wire              cmp_run_in_stop,
    output wire              state_is_deep
);

    // ****************************************************************
    // registers
    // ****************************************************************
    reg  [7:0]        sys_opt_ff;
    reg  [7:0]        pwr_one_ff;
    reg               ppd_sel_ff;
    reg               ppd_flag_ff;
    reg  [7:0]        dbg_ff;
    reg  [7:0]        clk_ff;
    reg  [1:0]        state_ff;
    reg  [1:0]        nxt_state;
    reg               reg_on_ff;
    reg               dbg_keep_ff;
    reg               ack_ff;

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    // three stages; a level change counts only once stages two and three
    // agree, and the held value bridges the cycle in which they differ
    reg  [WAKE_W+1:0] sync1_ff;
    reg  [WAKE_W+1:0] sync2_ff;
    reg  [WAKE_W+1:0] sync3_ff;
    reg  [WAKE_W+1:0] hold_ff;
    wire [WAKE_W+1:0] pin_raw;
    wire [WAKE_W+1:0] pin_val;

    assign pin_raw = {~reset_pin_n, irq_pin, port_pin_irq};

    genvar gi;
    generate
        for (gi = 0; gi < WAKE_W + 2; gi = gi + 1)
        begin : g_sync
            assign pin_val[gi] = (sync2_ff[gi] & sync3_ff[gi])
                               | (hold_ff[gi] & (sync2_ff[gi] | sync3_ff[gi]));
        end
    endgenerate

    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1_ff <= {(WAKE_W+2){1'b0}};
            sync2_ff <= {(WAKE_W+2){1'b0}};
            sync3_ff <= {(WAKE_W+2){1'b0}};
            hold_ff  <= {(WAKE_W+2){1'b0}};
        end
        else
        begin
            sync1_ff <= pin_raw;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            hold_ff  <= pin_val;
        end
    end

    wire rst_pin_act = pin_val[WAKE_W+1];
    wire pin_wake    = pin_val[WAKE_W] | (|pin_val[WAKE_W-1:0]); // RULE_07
    wire int_wake    = lvw_irq_evt | adc_done_irq | cmp_irq | rtc_irq
                     | can_wake_irq | serial_rx_irq; // RULE_08

    // ****************************************************************
    // mode selection
    // ****************************************************************
    wire stop_en = sys_opt_ff[`LPSC_BIT_STOP_EN];
    wire dbg_en  = dbg_ff[`LPSC_BIT_DBG_EN];
    wire lvd_en  = pwr_one_ff[`LPSC_BIT_LVD_EN];
    wire lvd_all = lvd_en & pwr_one_ff[`LPSC_BIT_LVD_STOP_EN];
    wire in_stop = (state_ff == `LPSC_ST_SHALLOW) |
                   (state_ff == `LPSC_ST_DEEP);
    wire shallow = (state_ff == `LPSC_ST_SHALLOW);
    wire deep    = (state_ff == `LPSC_ST_DEEP);
    wire stop_go = stop_exec & (state_ff == `LPSC_ST_RUN);
    // only the reset pin or an enabled rtc event may end the deep state
    wire deep_wake = rst_pin_act | (rtc_irq & rtc_enabled); // RULE_15
    wire sh_exit   = rst_pin_act | pin_wake | int_wake | lvd_reset_evt;
    wire bkgd_go   = dbg_bkgd_cmd & dbg_en; // RULE_13

    always @*
    begin
        nxt_state = state_ff;
        case (state_ff)
            `LPSC_ST_RUN:
            begin
                if (stop_exec & stop_en)
                begin
                    if (dbg_en | lvd_all)
                        nxt_state = `LPSC_ST_SHALLOW; // RULE_02 RULE_03
                    else if (ppd_sel_ff)
                        nxt_state = `LPSC_ST_DEEP; // RULE_04
                    else
                        nxt_state = `LPSC_ST_SHALLOW; // RULE_04
                end
            end
            `LPSC_ST_SHALLOW:
            begin
                if (dbg_bkgd_cmd & dbg_en)
                    nxt_state = `LPSC_ST_BKGD; // RULE_13
                else if (sh_exit)
                    nxt_state = `LPSC_ST_RUN; // RULE_07 RULE_08
            end
            `LPSC_ST_DEEP:
            begin
                if (deep_wake)
                    nxt_state = `LPSC_ST_RUN; // RULE_15
            end
            default:
            begin
                nxt_state = `LPSC_ST_BKGD;
            end
        endcase
    end

    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff           <= `LPSC_ST_RUN;
            reg_on_ff          <= 1'b1;
            dbg_keep_ff        <= 1'b0;
            illegal_op_reset   <= 1'b0;
            reset_vector_fetch <= 1'b0;
            irq_vector_fetch   <= 1'b0;
            por_like_reset     <= 1'b0;
            dbg_mem_refused    <= 1'b0;
            dbg_err_stopwait   <= 1'b0;
        end
        else
        begin
            state_ff         <= nxt_state;
            illegal_op_reset <= stop_go & ~stop_en; // RULE_01
            if (stop_go & stop_en)
            begin
                reg_on_ff   <= dbg_en | lvd_all; // RULE_10 RULE_11
                dbg_keep_ff <= dbg_en; // RULE_11
            end
            else if (nxt_state == `LPSC_ST_RUN)
            begin
                reg_on_ff   <= 1'b1;
                dbg_keep_ff <= 1'b0;
            end
            // reset pin wins over interrupts for the vector choice
            // in shallow stop a background command in the same cycle takes precedence
            reset_vector_fetch <= (shallow & rst_pin_act & ~bkgd_go)
                                | (deep & deep_wake); // RULE_09 RULE_16
            irq_vector_fetch   <= shallow & ~rst_pin_act & sh_exit
                                & ~bkgd_go; // RULE_09
            por_like_reset     <= deep & deep_wake; // RULE_16
            dbg_mem_refused    <= in_stop & dbg_mem_status_cmd; // RULE_12
            dbg_err_stopwait   <= in_stop & dbg_mem_status_cmd; // RULE_12
        end
    end

    // ****************************************************************
    // power, clock and pin-latch controls
    // ****************************************************************
    assign state_is_deep    = deep;
    assign dbg_accept_all   = (state_ff == `LPSC_ST_BKGD); // RULE_13
    assign core_clk_en      = ~in_stop; // RULE_05 RULE_06
    assign periph_clk_en    = ~in_stop; // RULE_20
    assign dbg_clk_en       = ~in_stop | dbg_keep_ff; // RULE_11
    assign regulator_active = ~in_stop | reg_on_ff; // RULE_10
    assign power_down_n     = ~deep; // RULE_14
    // ram is never powered down
    assign ram_retain       = 1'b1;
    // latches close on deep entry and open only on the ack write
    assign pin_latch_hold   = deep | ppd_flag_ff; // RULE_14 RULE_17 RULE_19
    assign ref_irclk_run    = ~in_stop | (shallow & clk_ff[`LPSC_BIT_IRCLK_EN]
                              & clk_ff[`LPSC_BIT_IREF_STEN]); // RULE_05
    assign ref_erclk_run    = ~in_stop | (shallow & clk_ff[`LPSC_BIT_ERCLK_EN]
                              & clk_ff[`LPSC_BIT_EREF_STEN]
                              & (~clk_ff[`LPSC_BIT_HF_RANGE]
                              | lvd_en)); // RULE_22
    assign adc_run_in_stop  = shallow & clk_ff[`LPSC_BIT_ADC_ACLK]
                              & lvd_en; // RULE_21
    assign cmp_run_in_stop  = shallow & lvd_en; // RULE_21

    // ****************************************************************
    // register slave
    // ****************************************************************
    wire wr = avs_write;
    wire rd = avs_read;
    wire wr_ack = wr & (avs_address == `LPSC_ADDR_PWR_CTRL_TWO)
                & avs_writedata[`LPSC_BIT_PPD_ACK];

    // one wait state on every access; read data is loaded during it
    assign avs_waitrequest = (wr | rd) & ~ack_ff;

    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ack_ff       <= 1'b0;
            avs_readdata <= 32'h0000_0000;
            sys_opt_ff   <= `LPSC_RST_SYS_OPT;
            pwr_one_ff   <= `LPSC_RST_PWR_ONE;
            ppd_sel_ff   <= 1'b0;
            ppd_flag_ff  <= 1'b0;
            dbg_ff       <= `LPSC_RST_DBG;
            clk_ff       <= `LPSC_RST_CLK;
            lvd_low_trip_sel <= 1'b0;
        end
        else
        begin
            ack_ff <= (wr | rd) & ~ack_ff;
            if (deep & deep_wake)
            begin
                // power-on style reset of control registers
                sys_opt_ff  <= `LPSC_RST_SYS_OPT; // RULE_16
                pwr_one_ff  <= `LPSC_POR_PWR_ONE; // RULE_16
                ppd_sel_ff  <= 1'b0;
                dbg_ff      <= `LPSC_RST_DBG;
                clk_ff      <= `LPSC_RST_CLK;
                lvd_low_trip_sel <= 1'b1; // RULE_16
                ppd_flag_ff <= 1'b1; // RULE_17
            end
            else
            begin
                // writes commit at the edge after the one that ends the wait state,
                // the same edge at which the master sees the answer
                if (wr & ack_ff)
                begin
                    if (avs_address == `LPSC_ADDR_SYS_OPT)
                        sys_opt_ff <= avs_writedata[7:0];
                    else if (avs_address == `LPSC_ADDR_PWR_CTRL_ONE)
                        pwr_one_ff <= avs_writedata[7:0];
                    else if (avs_address == `LPSC_ADDR_PWR_CTRL_TWO)
                        ppd_sel_ff <= avs_writedata[`LPSC_BIT_PPD_SEL];
                    else if (avs_address == `LPSC_ADDR_DBG_CTRL)
                        dbg_ff <= avs_writedata[7:0];
                    else if (avs_address == `LPSC_ADDR_CLK_CTRL)
                        clk_ff <= avs_writedata[7:0];
                end
                if (wr_ack & ack_ff)
                    ppd_flag_ff <= 1'b0; // RULE_23 RULE_17
            end
            if (rd & ~ack_ff)
            begin
                if (avs_address == `LPSC_ADDR_SYS_OPT)
                    avs_readdata <= {24'h000000, sys_opt_ff};
                else if (avs_address == `LPSC_ADDR_PWR_CTRL_ONE)
                    avs_readdata <= {24'h000000, pwr_one_ff};
                else if (avs_address == `LPSC_ADDR_PWR_CTRL_TWO)
                    avs_readdata <= {29'h00000000, 1'b0, ppd_flag_ff,
                                     ppd_sel_ff};
                else if (avs_address == `LPSC_ADDR_DBG_CTRL)
                    avs_readdata <= {24'h000000, dbg_ff};
                else if (avs_address == `LPSC_ADDR_CLK_CTRL)
                    avs_readdata <= {24'h000000, clk_ff};
                else if (avs_address == `LPSC_ADDR_STATUS)
                    avs_readdata <= {30'h00000000, state_ff};
                else
                    avs_readdata <= 32'h0000_0000;
            end
        end
    end

endmodule
`default_nettype wire

// >>> lpsc_stop_monitor.sv
// concurrent checks on the stop controller ports
`timescale 1ns/1ps
`default_nettype none
module lpsc_stop_monitor
#(
    parameter WAKE_W = 32
)
(
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic        avs_waitrequest,
    input wire logic        stop_exec,
    input wire logic        illegal_op_reset,
    input wire logic        reset_vector_fetch,
    input wire logic        irq_vector_fetch,
    input wire logic        por_like_reset,
    input wire logic        lvd_low_trip_sel,
    input wire logic        dbg_bkgd_cmd,
    input wire logic        dbg_mem_status_cmd,
    input wire logic        dbg_mem_refused,
    input wire logic        dbg_err_stopwait,
    input wire logic        core_clk_en,
    input wire logic        periph_clk_en,
    input wire logic        dbg_clk_en,
    input wire logic        regulator_active,
    input wire logic        power_down_n,
    input wire logic        pin_latch_hold,
    input wire logic        ram_retain,
    input wire logic        state_is_deep
);
    // ************************************************************
    // port relations
    // ************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    property p_bus_ack;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    property p_periph_gate;
        !core_clk_en |-> !periph_clk_en;
    endproperty
    property p_deep_power;
        state_is_deep |-> !power_down_n && pin_latch_hold && ram_retain
            && !core_clk_en;
    endproperty
    property p_dbg_reg;
        dbg_clk_en && !core_clk_en |-> regulator_active;
    endproperty
    property p_refuse;
        dbg_mem_status_cmd && !core_clk_en && !dbg_bkgd_cmd
            |=> dbg_mem_refused && dbg_err_stopwait;
    endproperty
    property p_latch_open;
        $fell(pin_latch_hold) |-> $past(avs_write && !avs_waitrequest
            && avs_address == 4'h2 && avs_writedata[2]);
    endproperty
    property p_illegal;
        illegal_op_reset |-> $past(stop_exec) && core_clk_en;
    endproperty
    property p_por;
        por_like_reset |-> reset_vector_fetch ##1
            lvd_low_trip_sel && pin_latch_hold;
    endproperty
    property p_vec_excl;
        reset_vector_fetch |-> !irq_vector_fetch;
    endproperty
    a_bus_ack: assert property (p_bus_ack) else $error("bus answer late");
    a_periph_gate: assert property (p_periph_gate)
        else $error("peripheral clock runs in stop");
    a_deep_power: assert property (p_deep_power)
        else $error("deep state power or latch wrong");
    a_dbg_reg: assert property (p_dbg_reg)
        else $error("regulator off with debug clock");
    a_refuse: assert property (p_refuse)
        else $error("status command not refused in stop");
    a_latch_open: assert property (p_latch_open)
        else $error("pin latch opened without ack");
    a_illegal: assert property (p_illegal)
        else $error("illegal reset without stop or with stop");
    a_por: assert property (p_por)
        else $error("deep wake outputs wrong");
    a_vec_excl: assert property (p_vec_excl)
        else $error("two vectors fetched at once");
    c_deep: cover property (state_is_deep);
    c_illegal: cover property (illegal_op_reset);
    c_refused: cover property (dbg_mem_refused);
    c_ack: cover property ($fell(pin_latch_hold));
endmodule
bind lpsc_stop_ctrl lpsc_stop_monitor #(.WAKE_W(WAKE_W)) u_mon (.*);
`default_nettype wire

// >>> lpsc_host_model.sv
// core and debug host model issuing stop and debug command pulses
`timescale 1ns/1ps
`default_nettype none
module lpsc_host_model
(
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       go,
    input  wire logic [1:0] cmd,
    input  wire logic       core_clk_en,
    output logic            stop_exec,
    output logic            dbg_bkgd_cmd,
    output logic            dbg_mem_status_cmd
);
    // ************************************************************
    // one-cycle command pulses
    // ************************************************************
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stop_exec          <= 1'b0;
            dbg_bkgd_cmd       <= 1'b0;
            dbg_mem_status_cmd <= 1'b0;
        end
        else
        begin
            // the core only executes a stop while it is clocked
            stop_exec          <= go && cmd == 2'h1 && core_clk_en;
            dbg_bkgd_cmd       <= go && cmd == 2'h2;
            dbg_mem_status_cmd <= go && cmd == 2'h3;
        end
    end
endmodule
`default_nettype wire

// >>> tb_top.sv
// self-checking bench for the stop mode controller
`timescale 1ns/1ps
`default_nettype none
`include "lpsc_map.vh"
`define CHK(nm,e,g) begin check_count++; \
    if ((g) !== (e)) begin errors++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_top;
    // ************************************************************
    // signals, design and host model
    // ************************************************************
    logic        clock = 1'b0, rst_n = 1'b0, avs_read = 1'b0;
    logic        avs_write = 1'b0, go = 1'b0, rtc_enabled = 1'b1;
    logic [3:0]  avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0, r;
    logic [1:0]  cmd = 2'h0, st;
    logic [9:0]  wk = 10'h0;
    logic [4:0]  pbit = 5'h0, seen = 5'h0;
    logic        dbg, low_volt_detector, lvds, ppd, clr_q = 1'b0;
    int          errors = 0, check_count = 0, i, k, n, src, idx;
    int          seed = 32'h1aaf330f;
    wire [31:0]  avs_readdata, port_pin_irq = {31'h0, wk[1]} << pbit;
    wire irq_pin = wk[0], lvd_reset_evt = wk[2], lvw_irq_evt = wk[3];
    wire adc_done_irq = wk[4], cmp_irq = wk[5], rtc_irq = wk[6];
    wire can_wake_irq = wk[7], serial_rx_irq = wk[8], reset_pin_n = !wk[9];
    wire avs_waitrequest, stop_exec, illegal_op_reset, reset_vector_fetch;
    wire irq_vector_fetch, por_like_reset, lvd_low_trip_sel, dbg_bkgd_cmd;
    wire dbg_mem_status_cmd, dbg_mem_refused, dbg_err_stopwait;
    wire dbg_accept_all, core_clk_en, periph_clk_en, dbg_clk_en;
    wire regulator_active, power_down_n, pin_latch_hold, ram_retain;
    wire ref_irclk_run, ref_erclk_run, adc_run_in_stop, cmp_run_in_stop;
    wire state_is_deep;
    lpsc_stop_ctrl #(.WAKE_W(32)) DUT (.*);
    lpsc_host_model u_host (.clock(clock), .rst_n(rst_n), .go(go),
        .cmd(cmd), .core_clk_en(core_clk_en), .stop_exec(stop_exec),
        .dbg_bkgd_cmd(dbg_bkgd_cmd), .dbg_mem_status_cmd(dbg_mem_status_cmd));
    always #2.5 clock = ~clock;
    always @(posedge clock)
        seen <= (clr_q ? 5'h0 : seen)
              | {dbg_mem_refused & dbg_err_stopwait, por_like_reset,
                        irq_vector_fetch, reset_vector_fetch, illegal_op_reset};
    // ************************************************************
    // tasks
    // ************************************************************
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int w;
        w = 0;
        @(posedge clock);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        @(negedge clock);
        for (w = 0; w < 50 && avs_waitrequest !== 1'b0; w++)
            @(negedge clock);
        `CHK("waitrequest", 1'b0, avs_waitrequest)
        @(posedge clock);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input string nm, input logic [3:0] a,
                          input logic [7:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        `CHK(nm, e, q[7:0])
    endtask
    task automatic send(input logic [1:0] c);
        @(posedge clock);
        go  <= 1'b1;
        cmd <= c;
        @(posedge clock);
        go  <= 1'b0;
    endtask
    task automatic clr;
        @(posedge clock);
        clr_q <= 1'b1;
        @(posedge clock);
        clr_q <= 1'b0;
    endtask
    task automatic wait_seen(input int b);
        int w;
        for (w = 0; w < 40 && seen[b] !== 1'b1; w++)
            @(posedge clock);
    endtask
    function automatic logic [1:0] exp_state(input logic d, v, s, p);
        if (d || (v && s) || !p)
            return `LPSC_ST_SHALLOW;
        return `LPSC_ST_DEEP;
    endfunction
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        #200000;
        errors++;
        tally_and_finish;
    end
    // ************************************************************
    // tests
    // ************************************************************
    initial
    begin
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        for (i = 0; i < 7; i++)
            rd_chk("reset_value", i[3:0], i == 0 ? 8'h01 : 8'h00);
        $display("test reset_values done");
        wr(4'h0, 32'h0);
        clr;
        send(2'h1);
        wait_seen(0);
        `CHK("illegal_reset", 1'b1, seen[0])
        `CHK("no_stop", 1'b1, core_clk_en)
        wr(4'h0, 32'h1);
        $display("test illegal_stop done");
        for (k = 0; k < 30; k++)
        begin
            r = $random(seed);
            if (k < 3)
                r[3:0] = k == 0 ? 4'h8 : (k == 1 ? 4'hf : 4'he);
            {ppd, lvds, low_volt_detector, dbg} = r[3:0];
            wr(4'h3, {31'h0, dbg});
            wr(4'h1, {30'h0, lvds, low_volt_detector});
            wr(4'h2, {31'h0, ppd});
            wr(4'h4, {26'h0, r[9:4]});
            st = exp_state(dbg, low_volt_detector, lvds, ppd);
            clr;
            send(2'h1);
            for (n = 0; n < 20 && core_clk_en !== 1'b0; n++)
                @(posedge clock);
            @(negedge clock);
            `CHK("deep", st == `LPSC_ST_DEEP, state_is_deep)
            `CHK("core_clk", 1'b0, core_clk_en)
            `CHK("periph_clk", 1'b0, periph_clk_en)
            `CHK("dbg_clk", dbg, dbg_clk_en)
            `CHK("regulator", dbg | (low_volt_detector & lvds), regulator_active)
            if (st == `LPSC_ST_SHALLOW)
            begin
                `CHK("irclk", r[4] & r[5], ref_irclk_run)
                `CHK("adc", 1'b0, adc_run_in_stop & !(r[9] & low_volt_detector))
                `CHK("cmp", 1'b0, cmp_run_in_stop & !low_volt_detector)
                `CHK("osc", 1'b0, ref_erclk_run & !(r[6] & r[7]
                    & (!r[8] | low_volt_detector)))
                clr;
                send(2'h3);
                wait_seen(4);
                `CHK("refused", 1'b1, seen[4])
                src = k % 10;
                idx = src == 9 ? 1 : 2;
                clr;
                @(posedge clock);
                pbit <= r[14:10];
                wk   <= 10'h1 << src;
                wait_seen(idx);
                @(posedge clock);
                wk <= 10'h0;
                `CHK("woke", 1'b1, core_clk_en)
                if (src != 2)
                    `CHK("vector", 1'b1, seen[idx])
                if (src != 2 && src != 9)
                    rd_chk("kept", 4'h1, {6'h0, lvds, low_volt_detector});
            end
            else
            begin
                @(posedge clock);
                wk          <= 10'h1ff;
                rtc_enabled <= 1'b0;
                repeat (10) @(posedge clock);
                `CHK("deep_holds", 1'b1, state_is_deep)
                rtc_enabled <= 1'b1;
                wk <= k[0] ? 10'h040 : 10'h200;
                wait_seen(3);
                @(posedge clock);
                wk <= 10'h0;
                `CHK("por", 1'b1, seen[3])
                `CHK("rst_vector", 1'b1, seen[1])
                `CHK("low_trip", 1'b1, lvd_low_trip_sel)
                `CHK("latched", 1'b1, pin_latch_hold)
                rd_chk("recovery", 4'h2, 8'h02);
                // port values would be restored here, before the ack
                wr(4'h2, 32'h4);
                rd_chk("ack_clears", 4'h2, 8'h00);
                `CHK("unlatched", 1'b0, pin_latch_hold)
            end
        end
        $display("test stop_modes done");
        wr(4'h3, 32'h1);
        send(2'h1);
        repeat (4) @(posedge clock);
        send(2'h2);
        repeat (4) @(posedge clock);
        `CHK("bkgd", 1'b1, dbg_accept_all)
        clr;
        send(2'h3);
        repeat (4) @(posedge clock);
        `CHK("no_refuse", 1'b0, seen[4])
        rd_chk("state", 4'h5, 8'h03);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        rd_chk("state_rst", 4'h5, 8'h00);
        $display("test background done");
        tally_and_finish;
    end
endmodule
`default_nettype wire
